// File: hdl/sfl_pkg.sv
// constants shared by the swing, length and count block
// assumes a 25 MHz system clock and a 32-bit AXI4-Lite register port
package sfl_pkg;
    // time base
    localparam int CLK_PERIOD_NS  = 40;
    localparam int TICK_PERIOD_NS = 1_000_000;                      // swing time step, 1 ms
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [7:0]  MS_PER_TENTH_S = 8'h64;                 // cycle time unit is 0.1 s
    localparam logic [9:0]  PCT_FULL       = 10'h3E8;               // 100.0 % in 0.1 % steps
    localparam logic [4:0]  PPM_SCALE      = 5'h0A;                 // pulses per metre in tenths
    localparam logic [5:0]  DIV_STEPS      = 6'h28;                 // 40-bit serial divide

    // register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_SWING_AMP = 8'h04;
    localparam logic [7:0] OFS_SWING_TIM = 8'h08;
    localparam logic [7:0] OFS_MAX_FREQ  = 8'h0C;
    localparam logic [7:0] OFS_FREQ_LIM  = 8'h10;
    localparam logic [7:0] OFS_LEN_CFG   = 8'h14;
    localparam logic [7:0] OFS_CNT_CFG   = 8'h18;
    localparam logic [7:0] OFS_STATUS    = 8'h1C;
    localparam logic [7:0] OFS_OUT_FREQ  = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h28;

    // field positions: low field at bit 0, high field at bit 16
    localparam int HI_LSB = 16;

    // reset values
    localparam logic [9:0]  RST_AMP_PCT  = 10'h000;
    localparam logic [9:0]  RST_JUMP_PCT = 10'h1F4;                 // 50.0 %
    localparam logic [15:0] RST_CYC_TIME = 16'h0064;                // 10.0 s
    localparam logic [9:0]  RST_RISE     = 10'h1F4;                 // 50.0 %
    localparam logic [15:0] RST_MAX_FREQ = 16'h1388;                // 50.00 Hz
    localparam logic [15:0] RST_LO_LIM   = 16'h0000;
    localparam logic [15:0] RST_HI_LIM   = 16'h1388;
    localparam logic [15:0] RST_TARGET   = 16'h03E8;                // 1000 m
    localparam logic [15:0] RST_PPM      = 16'h03E8;                // 100.0
    localparam logic [15:0] RST_TERM     = 16'h03E8;
    localparam logic [15:0] RST_INTER    = 16'h03E8;

    // interrupt bits
    localparam int IRQ_LEN   = 0;
    localparam int IRQ_TERM  = 1;
    localparam int IRQ_INTER = 2;
    localparam int IRQ_WRAP  = 3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SW_OFF  = 3'b001,
        SW_RISE = 3'b010,
        SW_FALL = 3'b100
    } sfl_sw_e;
endpackage

// File: hdl/sfl_in_sync.sv
// three-stage synchroniser with change filter and rising-edge pulse
// assumes asynchronous pin inputs; output is on ref_clk
`timescale 1ns/1ps
module sfl_in_sync #(
    parameter int W = 4
) (
    // clock and reset
    input  logic         ref_clk,
    input  logic         rstn,
    // pins and filtered result
    input  logic [W-1:0] din,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
        logic [W-1:0] rse;
    } sfl_sync_s;

    sfl_sync_s st_reg;
    sfl_sync_s st_next;

    // s1 feeds only s2; a rise is taken once s2 and s3 are both high, a fall as soon as they differ
    always_comb begin
        st_next     = st_reg;
        st_next.s1  = din;
        st_next.s2  = st_reg.s1;
        st_next.s3  = st_reg.s2;
        st_next.lvl = (st_reg.lvl & ~(st_reg.s2 ^ st_reg.s3)) | (st_reg.s2 & st_reg.s3);
        st_next.rse = st_next.lvl & ~st_reg.lvl;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.lvl;
    assign rise  = st_reg.rse;
endmodule

// File: hdl/sfl_swing_len_cnt.sv
// swing frequency generator, fixed-length meter and pulse counter
// assumes centre frequency from the frequency source, pins asynchronous
// Summary of operation
// - zero swing amplitude gives plain centre frequency
// - base select picks centre or maximum
// - centre mode: amplitude is centre times percent
// - maximum mode: amplitude is maximum times percent
// - jump step is amplitude times jump percent
// - swinging output clamped between lower and upper limit
// - full swing period equals cycle time
// - rise lasts cycle time times rise coefficient
// - fall lasts cycle time times the remainder
// - length is pulses divided by pulses per metre
// - length above target drives length-reached output
// - length reset input clears measured length
// - terminal count drives output and stops counting
// - intermediate count drives output, counting continues
`timescale 1ns/1ps
module sfl_swing_len_cnt
    import sfl_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    // clock and reset
    input  logic        ref_clk,
    input  logic        rstn,
    // axi4-lite slave
    input  logic [7:0]  s_axi_awaddr,
    input  logic        s_axi_awvalid,
    output logic        s_axi_awready,
    input  logic [31:0] s_axi_wdata,
    input  logic [3:0]  s_axi_wstrb,
    input  logic        s_axi_wvalid,
    output logic        s_axi_wready,
    output logic [1:0]  s_axi_bresp,
    output logic        s_axi_bvalid,
    input  logic        s_axi_bready,
    input  logic [7:0]  s_axi_araddr,
    input  logic        s_axi_arvalid,
    output logic        s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0]  s_axi_rresp,
    output logic        s_axi_rvalid,
    input  logic        s_axi_rready,
    // frequency
    input  logic [15:0] centre_freq,
    output logic [15:0] out_freq,
    // digital input pins
    input  logic        len_pulse_in,
    input  logic        cnt_pulse_in,
    input  logic        len_reset_in,
    input  logic        cnt_reset_in,
    // terminal outputs and interrupt
    output logic        length_reached,
    output logic        count_terminal,
    output logic        count_intermediate,
    output logic        irq
);
    typedef struct packed {
        logic        wa_got;
        logic [7:0]  wa_addr;
        logic        wd_got;
        logic [31:0] wd_data;
        logic [3:0]  wd_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        base_sel;
        logic [9:0]  amp_pct;
        logic [9:0]  jump_pct;
        logic [15:0] cyc_time;
        logic [9:0]  rise_coef;
        logic [15:0] max_freq;
        logic [15:0] lo_lim;
        logic [15:0] hi_lim;
        logic [15:0] target_len;
        logic [15:0] ppm;
        logic [15:0] term_cnt;
        logic [15:0] inter_cnt;
        logic [3:0]  irq_stat;
        logic [3:0]  irq_mask;
        sfl_sw_e     sw;
        logic [31:0] tick_cnt;
        logic [23:0] t_ms;
        logic        div_busy;
        logic [5:0]  div_cnt;
        logic [39:0] div_num;
        logic [24:0] div_rem;
        logic [23:0] div_den;
        logic [15:0] out_freq;
        logic [15:0] len;
        logic [19:0] len_sub;
        logic        len_hit;
        logic [15:0] cnt;
        logic        cnt_term;
        logic        cnt_inter;
    } sfl_state_s;

    sfl_state_s  st_reg;
    sfl_state_s  st_next;
    logic [3:0]  pin_lvl;
    logic [3:0]  pin_rise;

    // value times a 0.1 % setting, truncated
    function automatic logic [23:0] pct_of(input logic [23:0] v, input logic [9:0] p);
        logic [33:0] prod;
        prod   = 34'(v) * 34'(p);
        pct_of = 24'(prod / 34'(PCT_FULL));
    endfunction

    // byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            old[i*8 +: 8] = strb[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
        merge = old;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= OFS_IRQ_MASK);
    endfunction

    function automatic logic [31:0] rd_word(input sfl_state_s s, input logic [7:0] a);
        unique case (a)
            OFS_CTRL:      rd_word = {31'h0, s.base_sel};
            OFS_SWING_AMP: rd_word = {6'h0, s.jump_pct, 6'h0, s.amp_pct};
            OFS_SWING_TIM: rd_word = {6'h0, s.rise_coef, s.cyc_time};
            OFS_MAX_FREQ:  rd_word = {16'h0, s.max_freq};
            OFS_FREQ_LIM:  rd_word = {s.hi_lim, s.lo_lim};
            OFS_LEN_CFG:   rd_word = {s.ppm, s.target_len};
            OFS_CNT_CFG:   rd_word = {s.inter_cnt, s.term_cnt};
            OFS_STATUS:    rd_word = {s.cnt, s.len};
            OFS_OUT_FREQ:  rd_word = {16'h0, s.out_freq};
            OFS_IRQ_STAT:  rd_word = {28'h0, s.irq_stat};
            OFS_IRQ_MASK:  rd_word = {28'h0, s.irq_mask};
            default:       rd_word = 32'h0;
        endcase
    endfunction

    // pins: {cnt reset, len reset, cnt pulse, len pulse}
    sfl_in_sync #(.W(4)) u_sync (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .din     ({cnt_reset_in, len_reset_in, cnt_pulse_in, len_pulse_in}),
        .level   (pin_lvl),
        .rise    (pin_rise)
    );

    // swing arithmetic from current settings
    logic [15:0] aw_abs;
    logic [15:0] jump_step;
    logic [16:0] span;
    logic [23:0] cycle_ms;
    logic [23:0] rise_ms;
    logic [23:0] fall_ms;
    logic        swing_on;
    always_comb begin
        aw_abs    = 16'(pct_of(24'(st_reg.base_sel ? st_reg.max_freq : centre_freq),
                               st_reg.amp_pct));
        jump_step = 16'(pct_of(24'(aw_abs), st_reg.jump_pct));
        span      = 17'({aw_abs, 1'b0}) - 17'(jump_step);
        cycle_ms  = 24'(st_reg.cyc_time) * 24'(MS_PER_TENTH_S);
        rise_ms   = pct_of(cycle_ms, st_reg.rise_coef);
        fall_ms   = cycle_ms - rise_ms;
        swing_on  = (st_reg.amp_pct != 10'h000) && (st_reg.cyc_time != 16'h0000);
    end

    // whole next state; bus, settings, swing, length and count
    always_comb begin
        logic [31:0] w;
        logic [3:0]  ev;
        logic [24:0] rem_sh;
        logic        ge;
        logic [23:0] seg;
        logic [16:0] q;
        logic signed [19:0] off;
        logic signed [19:0] f;
        logic [19:0] sub_add;
        logic [15:0] ppm_eff;
        w       = 32'h0;
        ev      = 4'h0;
        rem_sh  = 25'h0;
        ge      = 1'b0;
        seg     = 24'h0;
        q       = 17'h0;
        off     = 20'sh0;
        f       = 20'sh0;
        sub_add = 20'h0;
        ppm_eff = (st_reg.ppm == 16'h0000) ? 16'h0001 : st_reg.ppm;
        st_next = st_reg;

        // bus write: address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.wa_got  = 1'b1;
            st_next.wa_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.wd_got  = 1'b1;
            st_next.wd_data = s_axi_wdata;
            st_next.wd_strb = s_axi_wstrb;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.wa_got && st_reg.wd_got) begin
            w = merge(rd_word(st_reg, st_reg.wa_addr), st_reg.wd_data, st_reg.wd_strb);
            unique case (st_reg.wa_addr)
                OFS_CTRL:      st_next.base_sel = w[0];
                OFS_SWING_AMP: {st_next.jump_pct, st_next.amp_pct} = {w[25:16], w[9:0]};
                OFS_SWING_TIM: {st_next.rise_coef, st_next.cyc_time} = {w[25:16], w[15:0]};
                OFS_MAX_FREQ:  st_next.max_freq = w[15:0];
                OFS_FREQ_LIM:  {st_next.hi_lim, st_next.lo_lim} = w;
                OFS_LEN_CFG:   {st_next.ppm, st_next.target_len} = w;
                OFS_CNT_CFG:   {st_next.inter_cnt, st_next.term_cnt} = w;
                OFS_IRQ_MASK:  st_next.irq_mask = w[3:0];
                default:       st_next.irq_mask = st_reg.irq_mask;
            endcase
            st_next.wa_got = 1'b0;
            st_next.wd_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = mapped(st_reg.wa_addr) ? RESP_OKAY : RESP_SLVERR;
        end

        // bus read; a read of the interrupt status word clears it
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = rd_word(st_reg, s_axi_araddr);
            st_next.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            if (s_axi_araddr == OFS_IRQ_STAT) begin
                st_next.irq_stat = 4'h0;
            end
        end

        // 1 ms time base for the swing ramp
        st_next.tick_cnt = (st_reg.tick_cnt >= 32'(TICK_CYC - 1)) ? 32'h0
                                                                    : st_reg.tick_cnt + 32'h1;

        // no amplitude or no period: plain centre frequency
        if (!swing_on) begin
            st_next.sw       = SW_OFF;
            st_next.t_ms     = 24'h0;
            st_next.div_busy = 1'b0;
            st_next.out_freq = centre_freq;
        end else if (st_reg.sw == SW_OFF) begin
            st_next.sw   = SW_RISE;
            st_next.t_ms = 24'h0;
        end else if (st_reg.tick_cnt == 32'h0) begin
            seg = (st_reg.sw == SW_RISE) ? rise_ms : fall_ms;
            // turn at the end of each segment
            if (st_reg.t_ms + 24'h1 >= seg) begin
                st_next.sw   = (st_reg.sw == SW_RISE) ? SW_FALL : SW_RISE;
                st_next.t_ms = 24'h0;
                ev[IRQ_WRAP] = (st_reg.sw == SW_FALL);
            end else begin
                st_next.t_ms = st_reg.t_ms + 24'h1;
            end
            seg = (st_next.sw == SW_RISE) ? rise_ms : fall_ms;
            // ramp position is span * t / segment, done serially before the next tick
            st_next.div_busy = 1'b1;
            st_next.div_cnt  = DIV_STEPS;
            st_next.div_num  = 40'(span) * 40'(st_next.t_ms);
            st_next.div_rem  = 25'h0;
            st_next.div_den  = (seg == 24'h0) ? 24'h1 : seg;
        end else if (st_reg.div_busy) begin
            rem_sh           = {st_reg.div_rem[23:0], st_reg.div_num[39]};
            ge               = rem_sh >= 25'(st_reg.div_den);
            st_next.div_rem  = ge ? rem_sh - 25'(st_reg.div_den) : rem_sh;
            st_next.div_num  = {st_reg.div_num[38:0], ge};
            st_next.div_cnt  = st_reg.div_cnt - 6'h1;
            if (st_reg.div_cnt == 6'h1) begin
                st_next.div_busy = 1'b0;
                q = (st_next.div_num > 40'(span)) ? span : st_next.div_num[16:0];
                // each segment starts one jump step inside the peak
                off = 20'(aw_abs) - 20'(jump_step);
                off = (st_reg.sw == SW_RISE) ? 20'(q) - off : off - 20'(q);
                f   = 20'(centre_freq) + off;
                // clamp to limits
                // signed compare, so a ramp that dips below zero clamps low, not high
                if (f < signed'({4'h0, st_reg.lo_lim})) begin
                    f = 20'(st_reg.lo_lim);
                end
                if (f > signed'({4'h0, st_reg.hi_lim})) begin
                    f = 20'(st_reg.hi_lim);
                end
                st_next.out_freq = f[15:0];
            end
        end

        // length: tenths per pulse against pulses per metre
        if (pin_lvl[2]) begin
            st_next.len     = 16'h0;
            st_next.len_sub = 20'h0;
        end else begin
            sub_add = st_reg.len_sub + (pin_rise[0] ? 20'(PPM_SCALE) : 20'h0);
            if (sub_add >= 20'(ppm_eff)) begin
                st_next.len_sub = sub_add - 20'(ppm_eff);
                st_next.len     = (st_reg.len == 16'hFFFF) ? st_reg.len : st_reg.len + 16'h1;
            end else begin
                st_next.len_sub = sub_add;
            end
        end
        st_next.len_hit = st_reg.len > st_reg.target_len;

        if (pin_lvl[3]) begin
            st_next.cnt = 16'h0;
        end else if (pin_rise[1] && !st_reg.cnt_term) begin
            st_next.cnt = st_reg.cnt + 16'h1;
        end
        st_next.cnt_term  = st_next.cnt >= st_reg.term_cnt;
        st_next.cnt_inter = st_next.cnt >= st_reg.inter_cnt;

        // sticky events; a new event wins over a clearing read
        ev[IRQ_LEN]      = st_next.len_hit & ~st_reg.len_hit;
        ev[IRQ_TERM]     = st_next.cnt_term & ~st_reg.cnt_term;
        ev[IRQ_INTER]    = st_next.cnt_inter & ~st_reg.cnt_inter;
        st_next.irq_stat = st_next.irq_stat | ev;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg            <= '0;
            st_reg.jump_pct   <= RST_JUMP_PCT;
            st_reg.amp_pct    <= RST_AMP_PCT;
            st_reg.cyc_time   <= RST_CYC_TIME;
            st_reg.rise_coef  <= RST_RISE;
            st_reg.max_freq   <= RST_MAX_FREQ;
            st_reg.lo_lim     <= RST_LO_LIM;
            st_reg.hi_lim     <= RST_HI_LIM;
            st_reg.target_len <= RST_TARGET;
            st_reg.ppm        <= RST_PPM;
            st_reg.term_cnt   <= RST_TERM;
            st_reg.inter_cnt  <= RST_INTER;
            st_reg.sw         <= SW_OFF;
        end else begin
            st_reg <= st_next;
        end
    end

    // handshakes are combinational, data comes from flip-flops
    assign s_axi_awready      = !st_reg.wa_got && !st_reg.bvalid;
    assign s_axi_wready       = !st_reg.wd_got && !st_reg.bvalid;
    assign s_axi_bvalid       = st_reg.bvalid;
    assign s_axi_bresp        = st_reg.bresp;
    assign s_axi_arready      = !st_reg.rvalid;
    assign s_axi_rvalid       = st_reg.rvalid;
    assign s_axi_rdata        = st_reg.rdata;
    assign s_axi_rresp        = st_reg.rresp;
    assign out_freq           = st_reg.out_freq;
    assign length_reached     = st_reg.len_hit;
    assign count_terminal     = st_reg.cnt_term;
    assign count_intermediate = st_reg.cnt_inter;
    assign irq                = |(st_reg.irq_stat & st_reg.irq_mask);

    property p_no_swing;
        @(posedge ref_clk) disable iff (!rstn)
        (st_reg.amp_pct == 10'h000) |=> (out_freq == $past(centre_freq));
    endproperty
    a_no_swing: assert property (p_no_swing) else $error("swing active at zero amplitude");

    property p_clamp_hi;
        @(posedge ref_clk) disable iff (!rstn)
        (st_reg.div_busy && st_reg.div_cnt == 6'h1 && swing_on) |=> (out_freq <= st_reg.hi_lim);
    endproperty
    a_clamp_hi: assert property (p_clamp_hi) else $error("output above upper limit");

    property p_clamp_lo;
        @(posedge ref_clk) disable iff (!rstn)
        (st_reg.div_busy && st_reg.div_cnt == 6'h1 && swing_on && st_reg.lo_lim <= st_reg.hi_lim)
        |=> (out_freq >= st_reg.lo_lim);
    endproperty
    a_clamp_lo: assert property (p_clamp_lo) else $error("output below lower limit");

    property p_rise_end;
        @(posedge ref_clk) disable iff (!rstn)
        (swing_on && st_reg.sw == SW_RISE && st_reg.tick_cnt == 32'h0 &&
         st_reg.t_ms + 24'h1 >= rise_ms) |=> (st_reg.sw == SW_FALL && st_reg.t_ms == 24'h0);
    endproperty
    a_rise_end: assert property (p_rise_end) else $error("rise did not turn on time");

    property p_fall_end;
        @(posedge ref_clk) disable iff (!rstn)
        (swing_on && st_reg.sw == SW_FALL && st_reg.tick_cnt == 32'h0 &&
         st_reg.t_ms + 24'h1 >= fall_ms) |=> (st_reg.sw == SW_RISE);
    endproperty
    a_fall_end: assert property (p_fall_end) else $error("fall did not turn on time");

    property p_len_reached;
        @(posedge ref_clk) disable iff (!rstn)
        (st_reg.len > st_reg.target_len) |=> length_reached;
    endproperty
    a_len_reached: assert property (p_len_reached) else $error("length reached missing");

    property p_len_reset;
        @(posedge ref_clk) disable iff (!rstn)
        pin_lvl[2] |=> (st_reg.len == 16'h0) [*2];
    endproperty
    a_len_reset: assert property (p_len_reset) else $error("length not cleared");

    property p_term_stop;
        @(posedge ref_clk) disable iff (!rstn)
        (count_terminal && !pin_lvl[3]) |=> (st_reg.cnt == $past(st_reg.cnt));
    endproperty
    a_term_stop: assert property (p_term_stop) else $error("counting past terminal");

    property p_count_step;
        @(posedge ref_clk) disable iff (!rstn)
        (pin_rise[1] && !count_terminal && !pin_lvl[3])
        |=> (st_reg.cnt == $past(st_reg.cnt) + 16'h1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("pulse not counted");

    property p_inter_on;
        @(posedge ref_clk) disable iff (!rstn)
        (st_reg.cnt >= st_reg.inter_cnt && !pin_lvl[3]) ##1 $stable(st_reg.inter_cnt)
        |-> count_intermediate;
    endproperty
    a_inter_on: assert property (p_inter_on) else $error("intermediate output missing");
endmodule

// File: sim/sfl_pulse_src.sv
// pulse source that stands in for a field sensor on one digital input
// assumes the bench calls send() from one thread at a time
`timescale 1ns/1ps
module sfl_pulse_src (
    // clock
    input  logic ref_clk,
    // pin
    output logic pin
);
    initial pin = 1'b0;
    // whole pulses only
    // 4 cycles high and low keeps clear of the 2-cycle filter minimum
    task automatic send(input int n);
        repeat (n) begin
            repeat (4) @(posedge ref_clk);
            pin <= 1'b1;
            repeat (4) @(posedge ref_clk);
            pin <= 1'b0;
        end
        repeat (8) @(posedge ref_clk); // let the synchroniser drain
    endtask
endmodule

// File: sim/test_swing_freq_length_counter.sv
// bench for the swing, length and count block over axi4-lite
// assumes a small swing tick so one swing period fits the run
`timescale 1ns/1ps
module test_swing_freq_length_counter;
    import sfl_pkg::*;
    logic        ref_clk = 1'b0, rstn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, d, s_axi_rdata;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        len_reset_in = 1'b0, cnt_reset_in = 1'b0;
    logic [15:0] centre_freq = 16'h0BB8, out_freq;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        len_pulse_in, cnt_pulse_in, irq;
    logic        length_reached, count_terminal, count_intermediate;
    int          err_count = 0, tests_run = 0;
    always #20 ref_clk = ~ref_clk;
    // tick of 64 clocks keeps a 0.1 s swing period near 6400 cycles
    sfl_swing_len_cnt #(.TICK_CYC(64)) uut (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .centre_freq, .out_freq, .len_pulse_in, .cnt_pulse_in, .len_reset_in,
        .cnt_reset_in, .length_reached, .count_terminal, .count_intermediate, .irq);
    sfl_pulse_src src_l (.ref_clk, .pin(len_pulse_in));
    sfl_pulse_src src_c (.ref_clk, .pin(cnt_pulse_in));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // sweep one full swing period and compare the lowest and highest output seen
    task automatic span_chk(input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] mn, mx;
        mn = 16'hFFFF;
        mx = 16'h0000;
        repeat (6600) begin
            @(negedge ref_clk);
            if (out_freq < mn) mn = out_freq;
            if (out_freq > mx) mx = out_freq;
        end
        chk({mx, mn}, {hi, lo});
    endtask
    // each channel is judged at the rising edge and released right after it is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w, b;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b1;
        while (aw | w | b) begin
            @(posedge ref_clk);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (b && s_axi_bvalid) begin
                b = 1'b0;
                s_axi_bready <= 1'b0;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ar, rv;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        ar = 1'b1;
        rv = 1'b1;
        while (ar | rv) begin
            @(posedge ref_clk);
            if (ar && s_axi_arready) begin
                ar = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (rv && s_axi_rvalid) begin
                rv = 1'b0;
                v = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // watchdog sized well above the ~20700 cycles the sequence needs
    initial begin
        repeat (40000) @(posedge ref_clk);
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(negedge ref_clk);
        chk({16'h0, out_freq}, 32'h0BB8);
        rd(OFS_LEN_CFG, d, r); chk(d, {RST_PPM, RST_TARGET});
        rd(OFS_SWING_TIM, d, r); chk(d, {6'h00, RST_RISE, RST_CYC_TIME});
        rd(8'h2C, d, r); chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(OFS_IRQ_MASK, 32'h2);
        wr(OFS_CNT_CFG, 32'h0003_0005);
        src_c.send(3);
        chk({29'h0, irq, count_terminal, count_intermediate}, 32'h1);
        src_c.send(4);
        chk({29'h0, irq, count_terminal, count_intermediate}, 32'h7);
        rd(OFS_IRQ_STAT, d, r); chk(d, 32'h6);
        @(negedge ref_clk); chk({31'h0, irq}, 32'h0);
        wr(OFS_LEN_CFG, 32'h000A_0002);
        src_l.send(2); chk({31'h0, length_reached}, 32'h0);
        src_l.send(1); chk({31'h0, length_reached}, 32'h1);
        rd(OFS_STATUS, d, r); chk(d, 32'h0005_0003);
        len_reset_in <= 1'b1; cnt_reset_in <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rd(OFS_STATUS, d, r); chk(d, 32'h0);
        len_reset_in <= 1'b0; cnt_reset_in <= 1'b0;
        wr(OFS_LEN_CFG, 32'h0014_0000);
        src_l.send(4);
        rd(OFS_STATUS, d, r); chk(d, 32'h0000_0002);
        // equal limits pin any swinging value to one figure
        wr(OFS_FREQ_LIM, 32'h0FA0_0FA0);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_SWING_TIM, 32'h01F4_0001);
        wr(OFS_SWING_AMP, 32'h01F4_0064);
        rd(OFS_IRQ_STAT, d, r);
        repeat (6000) @(posedge ref_clk);
        chk({16'h0, out_freq}, 32'h0FA0);
        rd(OFS_IRQ_STAT, d, r); chk(d, 32'h0);
        repeat (800) @(posedge ref_clk);
        rd(OFS_IRQ_STAT, d, r); chk(d, 32'h8);
        // open limits: max base 50.00 Hz, 10 % swing, 50 % jump, 15 per ms ramp
        wr(OFS_FREQ_LIM, 32'h1388_0000);
        repeat (200) @(posedge ref_clk);
        span_chk(16'h09D3, 16'h0D9D);
        // centre base at 40.00 Hz: 10 % swing, 50 % jump, 12 per ms ramp
        wr(OFS_CTRL, 32'h0);
        centre_freq <= 16'h0FA0;
        repeat (200) @(posedge ref_clk);
        span_chk(16'h0E1C, 16'h1124);
        // low byte only: terminal count 5 becomes 7, intermediate stays 3
        s_axi_wstrb <= 4'h1;
        wr(OFS_CNT_CFG, 32'hFFFF_FF07);
        rd(OFS_CNT_CFG, d, r); chk(d, 32'h0003_0007);
        wrap_up();
    end
endmodule
